// ### hw/flash_svc_pkg.sv
// Package: constants, codes and state carriers of the flash supervisory service block
package flash_svc_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] OFF_PARAM0 = 8'h00;
	localparam logic [7:0] OFF_CALL = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [7:0] OFF_ACC = 8'h28;
	localparam logic [7:0] OFF_IDX = 8'h2c;
	// Parameter block slots (F8h..FFh)
	localparam logic [2:0] PS_SECURITY_KEY_SLOT = 3'h0;
	localparam logic [2:0] PS_STACK_KEY_SLOT = 3'h1;
	localparam logic [2:0] PS_SEL = 3'h2;
	localparam logic [2:0] PS_CLOCK = 3'h4;
	localparam logic [2:0] PS_DELAY = 3'h6;
	// Call keys and function codes
	localparam logic [7:0] SECURITY_KEY_SLOT_VALUE = 8'h3a;
	localparam logic [7:0] SP_KEY_OFFSET = 8'h03;
	localparam logic [7:0] FN_BOOT = 8'h00;
	localparam logic [7:0] FN_ERASE = 8'h03;
	localparam logic [7:0] FN_PROTECT = 8'h04;
	localparam logic [7:0] FN_BULK = 8'h05;
	localparam logic [7:0] FN_TABLE = 8'h06;
	localparam logic [7:0] FN_CKSUM = 8'h07;
	// Result codes
	localparam logic [7:0] RC_OK = 8'h00;
	localparam logic [7:0] RC_DENIED = 8'h01;
	localparam logic [7:0] RC_SOFT_RESET = 8'h02;
	localparam logic [7:0] RC_HALT = 8'h03;
	// Protection levels
	localparam logic [1:0] LVL_OPEN = 2'h0;
	localparam logic [1:0] LVL_READ_PROT = 2'h1;
	localparam logic [1:0] LVL_NO_EXT_WRITE = 2'h2;
	localparam logic [1:0] LVL_NO_INT_WRITE = 2'h3;
	// Flash geometry
	localparam logic [14:0] PROT_ROW_ADDR = 15'h4000;
	localparam logic [14:0] TABLE_ROW_ADDR = 15'h4080;
	localparam logic [7:0] SRAM_PROT_BASE = 8'h80;
	localparam logic [5:0] PROT_LAST_BYTE = 6'h3f;
	localparam logic [2:0] TABLE_LAST_BYTE = 3'h7;
	localparam logic [8:0] ALL_USER_BLOCKS = 9'h100;
	localparam logic [0:0] MACRO_TOP = 1'h0;
	localparam logic [7:0] TRIM_IDX_VALUE = 8'hff;
	// Pulse timing: cycles per clock-divider step
	localparam logic [15:0] PULSE_SCALE = 16'h0004;

	typedef enum logic [3:0] {S_IDLE, S_CHECK, S_PULSE, S_BULK, S_BULK_NEXT, S_PR_RD, S_PR_MERGE,
		S_TB_RD, S_TB_DATA, S_CK_RD, S_CK_DATA} fsm_t;
	typedef enum logic [2:0] {OP_NONE, OP_ERASE_BLOCK, OP_ERASE_USER, OP_PROG_ZERO, OP_ERASE_PROT,
		OP_PROG_PROT} flash_op_t;
	typedef enum logic [1:0] {T_IDLE, T_SETUP, T_PULSE} tphase_t;

	typedef struct packed {
		logic [14:0] addr;
		logic rd;
		flash_op_t op;
		logic [0:0] macro;
	} flash_req_t;

	typedef struct packed {
		fsm_t fsm;
		fsm_t after;
		logic ap;
		logic [5:0] aaddr;
		logic awr;
		logic hready;
		logic [31:0] hrdata;
		logic [7:0][7:0] param;
		logic [7:0] acc;
		logic [7:0] xr;
		logic [7:0] func;
		logic [7:0] sp;
		logic [7:0] sel;
		logic busy;
		logic done;
		logic done_flag;
		logic halt;
		logic tmr_start;
		logic [14:0] cnt;
		logic [2:0] step;
		logic [0:0] macro;
		logic [63:0][7:0] prot;
		flash_req_t flash;
		logic [7:0] sram_addr;
		logic sram_rd;
	} ctl_state_t;

	typedef struct packed {
		tphase_t phase;
		logic [15:0] cnt;
		logic pulse;
		logic done;
	} timer_state_t;

	function automatic logic [15:0] pulse_cycles(input logic [7:0] clock_div);
		pulse_cycles = 16'({8'h00, clock_div} + 16'h0001) * PULSE_SCALE;
	endfunction
endpackage

// ### hw/flash_pulse_timer.sv
// Program/erase pulse timer: setup delay then a pulse whose width follows the clock divider
`timescale 1ns/1ps
module flash_pulse_timer (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Request
	input wire logic start,
	input wire logic [7:0] clock_div,
	input wire logic [7:0] delay,
	// Result
	output logic pulse_q,
	output logic done_q
);
	import flash_svc_pkg::*;
	timer_state_t t, n;
	logic [15:0] width_seen;

	always_comb begin
		n = t;
		n.done = 1'b0;
		case (t.phase)
			T_IDLE: begin
				if (start) begin
					n.phase = T_SETUP;
					n.cnt = {8'h00, delay};
				end
			end
			T_SETUP: begin
				if (t.cnt == 16'h0000) begin
					n.phase = T_PULSE;
					n.pulse = 1'b1;
					n.cnt = pulse_cycles(clock_div) - 16'h0001;
				end else begin
					n.cnt = t.cnt - 16'h0001;
				end
			end
			T_PULSE: begin
				if (t.cnt == 16'h0000) begin
					n.phase = T_IDLE;
					n.pulse = 1'b0;
					n.done = 1'b1;
				end else begin
					n.cnt = t.cnt - 16'h0001;
				end
			end
			default: n.phase = T_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			t <= '0;
		end else begin
			t <= n;
		end
	end

	assign pulse_q = t.pulse;
	assign done_q = t.done;

	// Helper count of the pulse length for the width check
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			width_seen <= 16'h0000;
		end else if (t.pulse) begin
			width_seen <= width_seen + 16'h0001;
		end else begin
			width_seen <= 16'h0000;
		end
	end

	a_pulse_width_divider: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(t.pulse) |-> width_seen == pulse_cycles(clock_div))
		else $error("flash pulse width does not match clock divider");
endmodule // flash_pulse_timer

// ### hw/flash_svc.sv
// Flash supervisory service block: erase, protect, bulk erase, table read, checksum
// Notes on behaviour
// - Program and erase pulse width follows the caller's clock-divider slot.
// - Block erase clears one aligned 64-byte block picked by the selector.
// - Erase of a write-locked block aborts: accumulator and stack key 00h, code 01h.
// - Block erase never changes that block's protection level.
// - Two-bit level: open, read-protected, no external write, no internal write.
// - Protection byte k holds blocks 4k..4k+3, lowest block in low bit pair.
// - Indexed flash reads are always allowed whatever the protection level.
// - Protection only rises; bulk erase alone clears it to zeros. Here reset also zeroes the protection bytes.
// - Protect ORs 64 SRAM bytes from 80h into the protection block.
// - Bulk erase goes top macro down: erase, program zeros, erase again.
// - Then each protection block, top macro first, is erased and zero filled.
// - Bulk erase leaves the three hidden blocks above protection untouched.
// - Table space is one 64-byte row of eight 8-byte tables.
// - Table read uses only the low three selector bits.
// - Table read copies the eight table bytes into slots F8h..FFh.
// - Identification table read returns the 16-bit die revision in A and X.
// - Trim table read sets X to FFh and A to the internal revision count.
// - Checksum covers blocks from 0; selector 1 is block 0, 0 means 256 blocks.
// - Checksum adds bytes into first key slot, carry into the second.
// - A key mismatch on any function but boot reset halts the processor.
// - Outcome codes: 00h ok, 01h denied, 02h soft reset, 03h fatal halt.
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module flash_svc #(
	parameter logic [15:0] REVISION_ID = 16'h0001, // Arbitrary value
	parameter logic [7:0] INTERNAL_REV = 8'h00 // Arbitrary value
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Flash macro
	output flash_svc_pkg::flash_req_t flash_req,
	output logic flash_pulse,
	input wire logic [7:0] flash_rdata,
	// SRAM read port
	output logic [7:0] sram_addr,
	output logic sram_rd,
	input wire logic [7:0] sram_rdata,
	// Processor
	output logic cpu_halt,
	output logic call_done
);
	import flash_svc_pkg::*;

	ctl_state_t s, n;
	logic tmr_done;
	logic [8:0] ck_blocks;
	logic [14:0] ck_last;
	logic [8:0] ck_sum;
	logic [7:0] wr_off;

	// Level of one block from the packed protection bytes
	function automatic logic [1:0] prot_level(input logic [63:0][7:0] p, input logic [7:0] blk);
		logic [7:0] b;
		b = p[blk[7:2]];
		prot_level = 2'(b >> {blk[1:0], 1'b0});
	endfunction

	function automatic ctl_state_t finish(input ctl_state_t x);
		ctl_state_t y;
		y = x;
		y.busy = 1'b0;
		y.done = 1'b1;
		y.done_flag = 1'b1;
		y.fsm = S_IDLE;
		finish = y;
	endfunction

	function automatic ctl_state_t start_op(input ctl_state_t x, input flash_op_t op,
		input logic [14:0] addr, input fsm_t after);
		ctl_state_t y;
		y = x;
		y.flash.op = op;
		y.flash.addr = addr;
		y.tmr_start = 1'b1;
		y.after = after;
		y.fsm = S_PULSE;
		start_op = y;
	endfunction

	assign ck_blocks = (s.sel == 8'h00) ? ALL_USER_BLOCKS : {1'b0, s.sel};
	assign ck_last = 15'({ck_blocks, 6'h00} - 15'h0001);
	assign ck_sum = {1'b0, s.param[PS_SECURITY_KEY_SLOT]} + {1'b0, flash_rdata};
	assign wr_off = {s.aaddr, 2'b00};

	always_comb begin
		n = s;
		n.done = 1'b0;
		n.tmr_start = 1'b0;
		n.flash.rd = 1'b0;
		n.sram_rd = 1'b0;
		// Bus data phase; one wait state so read data leaves a flop
		if (s.ap) begin
			n.ap = 1'b0;
			n.hready = 1'b1;
			n.hrdata = 32'h0000_0000;
			if (s.awr) begin
				if (wr_off < OFF_CALL && !s.busy) begin
					n.param[s.aaddr[2:0]] = hwdata[7:0];
				end else if (wr_off == OFF_CALL && !s.busy && !s.halt) begin
					n.func = hwdata[7:0];
					n.sp = hwdata[15:8];
					n.busy = 1'b1;
					n.done_flag = 1'b0;
					n.fsm = S_CHECK;
				end
			end else if (wr_off < OFF_CALL) begin
				n.hrdata = {24'h000000, s.param[s.aaddr[2:0]]};
			end else if (wr_off == OFF_CALL) begin
				n.hrdata = {16'h0000, s.sp, s.func};
			end else if (wr_off == OFF_STATUS) begin
				n.hrdata = {29'h0, s.halt, s.done_flag, s.busy};
			end else if (wr_off == OFF_ACC) begin
				n.hrdata = {24'h000000, s.acc};
			end else if (wr_off == OFF_IDX) begin
				n.hrdata = {24'h000000, s.xr};
			end
		end else if (hsel && htrans[1] && hready) begin
			n.ap = 1'b1;
			n.aaddr = haddr[7:2];
			n.awr = hwrite;
			n.hready = 1'b0;
		end

		case (s.fsm)
			S_IDLE: begin
			end
			S_CHECK: begin
				n.sel = s.param[PS_SEL];
				n.cnt = 15'h0000;
				if (s.func == FN_BOOT) begin
					n.param[PS_SECURITY_KEY_SLOT] = RC_SOFT_RESET;
					n = finish(n);
				end else if (s.param[PS_SECURITY_KEY_SLOT] != SECURITY_KEY_SLOT_VALUE ||
					s.param[PS_STACK_KEY_SLOT] != s.sp + SP_KEY_OFFSET) begin
					n.halt = 1'b1;
					n.param[PS_SECURITY_KEY_SLOT] = RC_HALT;
					n = finish(n);
				end else begin
					case (s.func)
						FN_ERASE: begin
							// Internal erase is refused only when internal writes are locked
							if (prot_level(s.prot, s.param[PS_SEL]) == LVL_NO_INT_WRITE) begin
								n.acc = 8'h00;
								n.param[PS_STACK_KEY_SLOT] = 8'h00;
								n.param[PS_SECURITY_KEY_SLOT] = RC_DENIED;
								n = finish(n);
							end else begin
								n = start_op(n, OP_ERASE_BLOCK, {1'b0, s.param[PS_SEL], 6'h00}, S_IDLE);
							end
						end
						FN_PROTECT: n.fsm = S_PR_RD;
						FN_BULK: begin
							n.macro = MACRO_TOP;
							n.step = 3'h0;
							n.fsm = S_BULK;
						end
						FN_TABLE: n.fsm = S_TB_RD;
						FN_CKSUM: begin
							n.param[PS_SECURITY_KEY_SLOT] = 8'h00;
							n.param[PS_STACK_KEY_SLOT] = 8'h00;
							n.fsm = S_CK_RD;
						end
						default: begin
							// Functions not served here stop the processor
							n.halt = 1'b1;
							n.param[PS_SECURITY_KEY_SLOT] = RC_HALT;
							n = finish(n);
						end
					endcase
				end
			end
			S_PULSE: begin
				if (tmr_done) begin
					n.flash.op = OP_NONE;
					if (s.after == S_IDLE) begin
						n.acc = 8'h00;
						n.param[PS_SECURITY_KEY_SLOT] = RC_OK;
						n = finish(n);
					end else begin
						n.fsm = s.after;
					end
				end
			end
			S_BULK: begin
				n.flash.macro = s.macro;
				case (s.step)
					3'h0: n = start_op(n, OP_ERASE_USER, 15'h0000, S_BULK_NEXT);
					3'h1: n = start_op(n, OP_PROG_ZERO, 15'h0000, S_BULK_NEXT);
					3'h2: n = start_op(n, OP_ERASE_USER, 15'h0000, S_BULK_NEXT);
					// Only the protection row is hit; rows above it are never addressed
					3'h3: n = start_op(n, OP_ERASE_PROT, PROT_ROW_ADDR, S_BULK_NEXT);
					default: n = start_op(n, OP_PROG_PROT, PROT_ROW_ADDR, S_BULK_NEXT);
				endcase
			end
			S_BULK_NEXT: begin
				n.fsm = S_BULK;
				if (s.step < 3'h2 || s.step == 3'h3) begin
					n.step = s.step + 3'h1;
				end else if (s.step == 3'h2) begin
					n.step = (s.macro != 1'h0) ? 3'h0 : 3'h3;
					n.macro = (s.macro != 1'h0) ? s.macro - 1'h1 : MACRO_TOP;
				end else begin
					n.prot = '0;
					n.step = 3'h3;
					if (s.macro != 1'h0) begin
						n.macro = s.macro - 1'h1;
					end else begin
						n.acc = 8'h00;
						n.param[PS_SECURITY_KEY_SLOT] = RC_OK;
						n = finish(n);
					end
				end
			end
			S_PR_RD: begin
				n.sram_addr = SRAM_PROT_BASE + {2'b00, s.cnt[5:0]};
				n.sram_rd = 1'b1;
				n.fsm = S_PR_MERGE;
			end
			S_PR_MERGE: begin
				// OR only: a level can never drop here
				n.prot[s.cnt[5:0]] = s.prot[s.cnt[5:0]] | sram_rdata;
				if (s.cnt[5:0] == PROT_LAST_BYTE) begin
					n = start_op(n, OP_PROG_PROT, PROT_ROW_ADDR, S_IDLE);
				end else begin
					n.cnt = s.cnt + 15'h0001;
					n.fsm = S_PR_RD;
				end
			end
			S_TB_RD: begin
				n.flash.addr = TABLE_ROW_ADDR + {9'h000, s.sel[2:0], s.cnt[2:0]};
				n.flash.rd = 1'b1;
				n.fsm = S_TB_DATA;
			end
			S_TB_DATA: begin
				n.param[s.cnt[2:0]] = flash_rdata;
				if (s.cnt[2:0] == TABLE_LAST_BYTE) begin
					if (s.sel[2:0] == 3'h0) begin
						n.acc = REVISION_ID[15:8];
						n.xr = REVISION_ID[7:0];
					end else begin
						n.acc = INTERNAL_REV;
						n.xr = TRIM_IDX_VALUE;
					end
					n = finish(n);
				end else begin
					n.cnt = s.cnt + 15'h0001;
					n.fsm = S_TB_RD;
				end
			end
			S_CK_RD: begin
				// Plain indexed read, no protection check
				n.flash.addr = s.cnt;
				n.flash.rd = 1'b1;
				n.fsm = S_CK_DATA;
			end
			S_CK_DATA: begin
				n.param[PS_SECURITY_KEY_SLOT] = ck_sum[7:0];
				n.param[PS_STACK_KEY_SLOT] = s.param[PS_STACK_KEY_SLOT] + {7'h00, ck_sum[8]};
				if (s.cnt == ck_last) begin
					n = finish(n);
				end else begin
					n.cnt = s.cnt + 15'h0001;
					n.fsm = S_CK_RD;
				end
			end
			default: n.fsm = S_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.hready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	flash_pulse_timer u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(s.tmr_start),
		.clock_div(s.param[PS_CLOCK]),
		.delay(s.param[PS_DELAY]),
		.pulse_q(flash_pulse),
		.done_q(tmr_done)
	);

	assign hrdata = s.hrdata;
	assign hreadyout = s.hready;
	assign hresp = 1'b0;
	assign flash_req = s.flash;
	assign sram_addr = s.sram_addr;
	assign sram_rd = s.sram_rd;
	assign cpu_halt = s.halt;
	assign call_done = s.done;

	sequence bus_addr_phase;
		hsel && htrans[1] && hready;
	endsequence
	sequence one_wait_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	a_bus_wait_state: assert property (@(posedge hclk) disable iff (!hresetn)
		bus_addr_phase |=> one_wait_answer)
		else $error("bus answer not after exactly one wait state");

	a_erase_denied_codes: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.fsm == S_CHECK && s.func == FN_ERASE && !n.halt &&
		prot_level(s.prot, s.param[PS_SEL]) == LVL_NO_INT_WRITE)
		|=> s.param[PS_SECURITY_KEY_SLOT] == RC_DENIED && s.acc == 8'h00 && s.param[PS_STACK_KEY_SLOT] == 8'h00 && s.done)
		else $error("denied erase did not return its codes");

	a_erase_keeps_prot: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.fsm == S_PULSE && s.flash.op == OP_ERASE_BLOCK) |=> $stable(s.prot))
		else $error("block erase changed protection");

	a_prot_never_lowered: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.fsm != S_BULK_NEXT) |=> (s.prot & $past(s.prot)) == $past(s.prot))
		else $error("protection level lowered outside bulk erase");

	a_bad_key_halt: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.fsm == S_CHECK && s.func != FN_BOOT &&
		(s.param[PS_SECURITY_KEY_SLOT] != SECURITY_KEY_SLOT_VALUE || s.param[PS_STACK_KEY_SLOT] != s.sp + SP_KEY_OFFSET))
		|=> cpu_halt && s.param[PS_SECURITY_KEY_SLOT] == RC_HALT && call_done)
		else $error("bad key did not halt");

	a_table_sel_bits: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.fsm == S_TB_DATA) |-> flash_req.addr == TABLE_ROW_ADDR + {9'h000, s.sel[2:0], s.cnt[2:0]})
		else $error("table address ignores selector bits");

	a_trim_index_ff: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.fsm == S_TB_DATA && s.cnt[2:0] == TABLE_LAST_BYTE && s.sel[2:0] != 3'h0)
		|=> s.xr == TRIM_IDX_VALUE && s.acc == INTERNAL_REV)
		else $error("trim table read did not set index to FFh");

	a_one_call_only: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.busy && s.ap && s.awr && wr_off == OFF_CALL) |=> $stable(s.func) && $stable(s.sp))
		else $error("call taken while busy");
endmodule // flash_svc

// ### tb/flash_sram_model.sv
// Flash macro and SRAM model that sits beside the flash service block
`timescale 1ns/1ps
module flash_sram_model (
	// Clock
	input wire logic hclk,
	// Flash side
	input wire flash_svc_pkg::flash_req_t flash_req,
	input wire logic flash_pulse,
	output logic [7:0] flash_rdata,
	// SRAM side
	input wire logic [7:0] sram_addr,
	input wire logic sram_rd,
	output logic [7:0] sram_rdata
);
	import flash_svc_pkg::*;
	logic [7:0] flash [0:32767];
	logic [7:0] sram [0:255];
	flash_op_t ops [$];
	flash_op_t op_q;
	logic [14:0] addr_q;
	logic pulse_q;
	logic [7:0] flash_idle, sram_idle;
	initial begin
		for (int i = 0; i < 32768; i++) begin
			flash[i] = 8'(i * 7 + 3);
		end
		for (int i = 0; i < 256; i++) begin
			sram[i] = 8'h00;
		end
		flash_idle = 8'h00;
		sram_idle = 8'h00;
		pulse_q = 1'b0;
	end
	// Read data stands while the strobe stands; otherwise the lines toggle so stale data never matches
	assign flash_rdata = flash_req.rd ? flash[flash_req.addr] : flash_idle;
	assign sram_rdata = sram_rd ? sram[sram_addr] : sram_idle;
	always @(posedge hclk) begin
		flash_idle <= ~flash_rdata;
		sram_idle <= ~sram_rdata;
		pulse_q <= flash_pulse;
		if (flash_pulse) begin
			op_q <= flash_req.op;
			addr_q <= flash_req.addr;
		end
		// Contents change when the pulse ends
		if (pulse_q && !flash_pulse) begin
			ops.push_back(op_q);
			for (int i = 0; i < 16384; i++) begin
				if (op_q == OP_ERASE_USER || (op_q == OP_ERASE_BLOCK && i[13:6] == addr_q[13:6])) begin
					flash[i] = 8'hff;
				end else if (op_q == OP_PROG_ZERO) begin
					flash[i] = 8'h00;
				end
			end
			// Protection data is not carried on the link; the row gets the bulk erase pattern
			if (op_q == OP_ERASE_PROT || op_q == OP_PROG_PROT) begin
				for (int i = 0; i < 64; i++) begin
					flash[{addr_q[14:6], 6'(i)}] = (op_q == OP_ERASE_PROT) ? 8'hff : 8'h00;
				end
			end
		end
	end
endmodule // flash_sram_model

// ### tb/flash_svc_tb.sv
// Self-checking testbench of the flash supervisory service block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module flash_svc_tb;
	import flash_svc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, call_done, cpu_halt, sram_rd, flash_pulse, hreadyout, hresp, dp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] flash_rdata, sram_addr, sram_rdata, rnd;
	flash_req_t flash_req;
	logic [31:0] exp_q [$];
	logic [31:0] ex;
	int fail_count, comparisons, pw;
	flash_op_t exp_ops [3] = '{OP_ERASE_USER, OP_PROG_ZERO, OP_ERASE_USER};
	flash_svc #(.REVISION_ID(16'h5a3c), .INTERNAL_REV(8'h07)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_req(flash_req), .flash_pulse(flash_pulse),
		.flash_rdata(flash_rdata), .sram_addr(sram_addr), .sram_rd(sram_rd), .sram_rdata(sram_rdata),
		.cpu_halt(cpu_halt), .call_done(call_done));
	flash_sram_model u_mem (.hclk(hclk), .flash_req(flash_req), .flash_pulse(flash_pulse),
		.flash_rdata(flash_rdata), .sram_addr(sram_addr), .sram_rd(sram_rd), .sram_rdata(sram_rdata));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Ready is looked at on the falling edge: registered outputs there equal what the next rising edge samples
	task automatic wait_rdy();
		int n;
		logic r;
		n = 0;
		do begin
			@(negedge hclk);
			r = hreadyout;
			@(posedge hclk);
			n++;
		end while (r !== 1'b1 && n < 50);
		if (r !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t bus ready timeout", $time);
			end_of_test();
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) exp_q.push_back(e);
		wait_rdy();
	endtask
	task automatic setp(input logic [2:0] s, input logic [7:0] v);
		bus({3'h0, s, 2'h0}, 1'b1, {24'h0, v}, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(a, 1'b0, 32'h0, {24'h0, e});
	endtask
	task automatic call(input logic [7:0] f, input logic [7:0] k2off, input logic [7:0] sel);
		int n;
		rnd = lfsr(rnd);
		setp(PS_SECURITY_KEY_SLOT, SECURITY_KEY_SLOT_VALUE);
		setp(PS_STACK_KEY_SLOT, rnd + k2off);
		setp(PS_SEL, sel);
		setp(PS_CLOCK, 8'h01);
		setp(PS_DELAY, 8'h56);
		bus(OFF_CALL, 1'b1, {16'h0, rnd, f}, 32'h0);
		// A second call while the long checksum runs must be ignored
		if (f == FN_CKSUM && sel == 8'h00) begin
			bus(OFF_CALL, 1'b1, {16'h0, rnd, FN_BULK}, 32'h0);
			rd(OFF_STATUS, 8'h01);
		end
		pw = 0;
		n = 0;
		do begin
			@(negedge hclk);
			pw += int'(flash_pulse);
			n++;
		end while (call_done !== 1'b1 && n < 40000);
		if (call_done !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t call completion timeout", $time);
			end_of_test();
		end
		@(posedge hclk);
	endtask
	task automatic cksum(input logic [7:0] sel);
		int nb;
		logic [15:0] s;
		s = 16'h0;
		nb = (sel == 8'h00) ? 256 : int'(sel);
		for (int i = 0; i < nb * 64; i++) s += 16'(u_mem.flash[i]);
		call(FN_CKSUM, 8'h03, sel);
		rd(OFF_PARAM0, s[7:0]);
		rd(8'h04, s[15:8]);
	endtask
	// Reads are checked in the order issued; the bus takes one transfer at a time
	always @(negedge hclk) begin
		if (dp && hreadyout === 1'b1) begin
			dp = 1'b0;
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("[FAIL] %0t read with no expected value", $time);
			end else begin
				ex = exp_q.pop_front();
				`CHK(hrdata, ex)
				`CHK(hresp, 1'b0)
			end
		end
		if (hsel === 1'b1 && htrans[1] === 1'b1 && hreadyout === 1'b1) dp = !hwrite;
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rnd = 8'h57;
		dp = 1'b0;
		fail_count = 0;
		comparisons = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		call(FN_BOOT, 8'h04, 8'h00);
		rd(OFF_PARAM0, RC_SOFT_RESET);
		$display("test boot done");
		call(FN_TABLE, 8'h03, 8'hf8);
		rd(OFF_ACC, 8'h5a);
		rd(OFF_IDX, 8'h3c);
		for (int i = 0; i < 8; i++) rd(8'(4 * i), u_mem.flash[16'h4080 + i]);
		call(FN_TABLE, 8'h03, 8'h0d);
		rd(OFF_IDX, TRIM_IDX_VALUE);
		rd(OFF_ACC, 8'h07);
		for (int i = 0; i < 8; i++) rd(8'(4 * i), u_mem.flash[16'h40a8 + i]);
		$display("test table done");
		cksum(8'h01);
		cksum(8'h00);
		$display("test checksum done");
		call(FN_ERASE, 8'h03, 8'h02);
		`CHK(pw, 2 * int'(PULSE_SCALE))
		rd(OFF_PARAM0, RC_OK);
		rd(OFF_ACC, 8'h00);
		`CHK(u_mem.flash[128], 8'hff)
		`CHK(u_mem.flash[191], 8'hff)
		`CHK(u_mem.flash[127], 8'(127 * 7 + 3))
		`CHK(u_mem.flash[192], 8'(192 * 7 + 3))
		$display("test erase done");
		u_mem.sram[8'h80] = 8'hc0;
		call(FN_PROTECT, 8'h03, 8'h00);
		u_mem.sram[8'h80] = 8'h00;
		call(FN_PROTECT, 8'h03, 8'h00);
		call(FN_ERASE, 8'h03, 8'h03);
		`CHK(pw, 0)
		rd(OFF_PARAM0, RC_DENIED);
		rd(8'h04, 8'h00);
		rd(OFF_ACC, 8'h00);
		call(FN_ERASE, 8'h03, 8'h02);
		rd(OFF_PARAM0, RC_OK);
		call(FN_ERASE, 8'h03, 8'h03);
		rd(OFF_PARAM0, RC_DENIED);
		$display("test protect done");
		u_mem.ops.delete();
		call(FN_BULK, 8'h03, 8'h00);
		for (int i = 0; i < 3; i++) `CHK(u_mem.ops[i], exp_ops[i])
		`CHK(u_mem.ops[3], OP_ERASE_PROT)
		`CHK(u_mem.ops[4], OP_PROG_PROT)
		`CHK(u_mem.flash[16'h40c0], 8'(16'h40c0 * 7 + 3))
		`CHK(u_mem.flash[16'h4040], 8'(16'h4040 * 7 + 3))
		`CHK(u_mem.flash[16'h4000], 8'h00)
		`CHK(u_mem.flash[0], 8'hff)
		call(FN_ERASE, 8'h03, 8'h03);
		rd(OFF_PARAM0, RC_OK);
		$display("test bulk done");
		call(FN_ERASE, 8'h04, 8'h02);
		`CHK(cpu_halt, 1'b1)
		`CHK(pw, 0)
		rd(OFF_PARAM0, RC_HALT);
		rd(OFF_STATUS, 8'h06);
		$display("test halt done");
		end_of_test();
	end
endmodule // flash_svc_tb
